// [prr_ctrl.sv]
/*
 * Read prefetch, delayed-read retry and retry-counter policy of a PCIe to
 * PCI bridge, with its control register, interrupt status and mask.
 * Assumes request and credit pulses come from logic on REF_CLK.
 */
// Summary of operation
// - Mode bits 9:8 pick one-line (00) or full (10) fetch; 01 reserved.
// - Mode 11 disconnects the master after the first doubleword of a plain read.
// - Bit 10 clear: a repeat with a changed command keeps being retried.
// - Bit 10 set: MR, MRL, MRM may swap; same address and enables complete.
// - Full-prefetch reads cap each link read request at the size in bits 14:12.
// - Size code: 000/011/111 512, 001 128, 010 256, 100 1K, 101 2K, 110 4K bytes.
// - Bit 15 clear: credit update per two freed credits; set: per one credit.
// - Bit 16 sets on retry expiry, stays until reset or a one is written.
// - Bits 18:17 limit retries: 01 256, 10 64K, 11 2G.
// - Retry control 00 means the counter never expires.
// - Bit 19 clear enables the discard timer with bridge control bit 27.
// - Read line mode 7:6 at 10 gives full prefetch for read line commands.
`timescale 1ns/1ps
`default_nettype none
module prr_ctrl
    import prr_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic IRQ,
    input wire logic REQ_VALID,
    input wire prr_req_t REQ,
    input wire logic CPL_READY,
    output logic DEC_VALID,
    output prr_dec_t DEC,
    input wire logic CREDIT_FREED,
    output logic FC_UPDATE,
    input wire logic BRIDGE_DISCARD_BIT,
    output logic DISCARD_TIMER_EN
);
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic is_memrd(input logic [3:0] c);
        return (c == CMD_MR) || (c == CMD_MRL) || (c == CMD_MRM);
    endfunction

    function automatic logic [12:0] rd_size(input logic [2:0] code);
        unique case (code)
            3'h1: return SZ_128;
            3'h2: return SZ_256;
            3'h4: return SZ_1K;
            3'h5: return SZ_2K;
            3'h6: return SZ_4K;
            default: return SZ_512; // 000, 011, 111
        endcase
    endfunction

    function automatic prr_fetch_t policy(input logic [3:0] c, input logic pref,
                                          input logic [31:0] cw);
        logic [1:0] m;
        m = 2'h0;
        if (c == CMD_MRL) m = cw[F_RL_LO +: 2];
        else if (c == CMD_MRM) m = cw[F_RM_LO +: 2];
        else m = cw[F_MR_LO +: 2];
        if (c == CMD_MR && m == 2'h3) return FETCH_DISC1;
        if (!pref) return FETCH_DWORD;
        if (c == CMD_MR) return (m == 2'h2) ? FETCH_FULL : FETCH_LINE;
        return (m == 2'h0) ? FETCH_LINE : FETCH_FULL;
    endfunction

    function automatic logic [31:0] retry_limit(input logic [1:0] sel);
        unique case (sel)
            2'h1: return LIM_256;
            2'h2: return LIM_64K;
            2'h3: return LIM_2G;
            default: return 32'h0000_0000; // no limit
        endcase
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [31:0] ctrl, next_ctrl;
    logic [1:0] irq_stat, next_irq_stat;
    logic [1:0] irq_mask, next_irq_mask;
    logic [31:0] rdata, next_rdata;
    logic irq, next_irq;
    prr_state_t state, next_state;
    prr_req_t pend, next_pend;
    prr_fetch_t pend_fetch, next_pend_fetch;
    logic [31:0] rcnt, next_rcnt;
    logic dec_valid, next_dec_valid;
    prr_dec_t dec, next_dec;
    logic fc_cnt, next_fc_cnt;
    logic fc_upd, next_fc_upd;
    logic disc_en, next_disc_en;
    logic expire, cmd_retry;

    // --------------------------------------------------------------
    // delayed read tracking and retry counter
    // --------------------------------------------------------------
    // one delayed-read slot; a second address simply gets retried, which
    // costs throughput but keeps ordering trivial
    always_comb begin
        logic same_ab;
        logic cmd_ok;
        logic [31:0] lim;
        logic [31:0] cnt_inc;
        same_ab = 1'b0;
        cmd_ok = 1'b0;
        lim = retry_limit(ctrl[F_RETRY_CTL_LO +: 2]);
        cnt_inc = rcnt + 32'h0000_0001;
        next_state = state;
        next_pend = pend;
        next_pend_fetch = pend_fetch;
        next_rcnt = rcnt;
        next_dec_valid = 1'b0;
        next_dec = dec;
        expire = 1'b0;
        cmd_retry = 1'b0;
        if (REQ_VALID) begin
            next_dec_valid = 1'b1;
            unique case (state)
                ST_IDLE: begin
                    // first attempt is retried while the link read goes out
                    next_state = ST_PEND;
                    next_pend = REQ;
                    next_pend_fetch = policy(REQ.cmd, REQ.pref, ctrl);
                    next_rcnt = 32'h0000_0001;
                    next_dec.retry = 1'b1;
                    next_dec.data = 1'b0;
                    next_dec.fetch = policy(REQ.cmd, REQ.pref, ctrl);
                    next_dec.max_bytes = (policy(REQ.cmd, REQ.pref, ctrl) == FETCH_FULL)
                        ? rd_size(ctrl[F_MAXRD_LO +: 3]) : 13'h0000;
                end
                ST_PEND: begin
                    same_ab = (REQ.addr == pend.addr) && (REQ.be == pend.be);
                    cmd_ok = (REQ.cmd == pend.cmd) || (ctrl[F_SPECIAL]
                        && is_memrd(REQ.cmd) && is_memrd(pend.cmd));
                    next_dec.fetch = pend_fetch;
                    next_dec.max_bytes = 13'h0000;
                    if (same_ab && cmd_ok && CPL_READY) begin
                        // hand the data over; fetch carries the disconnect policy
                        next_dec.retry = 1'b0;
                        next_dec.data = 1'b1;
                        next_state = ST_IDLE;
                        next_rcnt = 32'h0000_0000;
                    end else begin
                        next_dec.retry = 1'b1;
                        next_dec.data = 1'b0;
                        cmd_retry = same_ab && !cmd_ok;
                        next_rcnt = cnt_inc;
                        // a zero limit never matches a nonzero count
                        if (lim != 32'h0000_0000 && cnt_inc == lim) begin
                            expire = 1'b1;
                            next_state = ST_IDLE;
                            next_rcnt = 32'h0000_0000;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state <= ST_IDLE;
            pend <= '0;
            pend_fetch <= FETCH_DWORD;
            rcnt <= 32'h0000_0000;
            dec_valid <= 1'b0;
            dec <= '0;
        end else begin
            state <= next_state;
            pend <= next_pend;
            pend_fetch <= next_pend_fetch;
            rcnt <= next_rcnt;
            dec_valid <= next_dec_valid;
            dec <= next_dec;
        end
    end

    // --------------------------------------------------------------
    // flow-control credit update pacing
    // --------------------------------------------------------------
    // one pending half-credit at most; switching granularity mid-count
    // just flushes it with the next freed credit
    always_comb begin
        next_fc_cnt = fc_cnt;
        next_fc_upd = 1'b0;
        if (CREDIT_FREED) begin
            if (ctrl[F_FC_ONE] || fc_cnt) begin
                next_fc_upd = 1'b1;
                next_fc_cnt = 1'b0;
            end else begin
                next_fc_cnt = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fc_cnt <= 1'b0;
            fc_upd <= 1'b0;
        end else begin
            fc_cnt <= next_fc_cnt;
            fc_upd <= next_fc_upd;
        end
    end

    // --------------------------------------------------------------
    // register file and interrupt
    // --------------------------------------------------------------
    // hardware sets win over a same-cycle write-one-to-clear
    always_comb begin
        next_ctrl = ctrl;
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        next_rdata = 32'h0000_0000;
        if (WR && ADDR == REG_CTRL) begin
            next_ctrl = (ctrl & ~CTRL_RW_MASK) | (WDATA & CTRL_RW_MASK);
            if (WDATA[F_RETRY_STAT]) next_ctrl[F_RETRY_STAT] = 1'b0;
        end
        if (WR && ADDR == REG_IRQ_STAT) next_irq_stat = irq_stat & ~WDATA[1:0];
        if (WR && ADDR == REG_IRQ_MASK) next_irq_mask = WDATA[1:0];
        if (expire) begin
            next_ctrl[F_RETRY_STAT] = 1'b1;
            next_irq_stat[I_EXPIRE] = 1'b1;
        end
        if (cmd_retry) next_irq_stat[I_CMD_RETRY] = 1'b1;
        if (RD) begin
            unique case (ADDR)
                REG_CTRL: next_rdata = ctrl;
                REG_IRQ_STAT: next_rdata = {30'h0, irq_stat};
                REG_IRQ_MASK: next_rdata = {30'h0, irq_mask};
                default: next_rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
        next_irq = |(next_irq_stat & next_irq_mask);
        next_disc_en = !next_ctrl[F_DISCARD_DIS] && BRIDGE_DISCARD_BIT;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl <= CTRL_RESET;
            irq_stat <= IRQ_RESET;
            irq_mask <= IRQ_RESET;
            rdata <= 32'h0000_0000;
            irq <= 1'b0;
            disc_en <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rdata <= next_rdata;
            irq <= next_irq;
            disc_en <= next_disc_en;
        end
    end

    assign RDATA = rdata;
    assign IRQ = irq;
    assign DEC_VALID = dec_valid;
    assign DEC = dec;
    assign FC_UPDATE = fc_upd;
    assign DISCARD_TIMER_EN = disc_en;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    chk_mr_full_fetch: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_IDLE && REQ.cmd == CMD_MR && REQ.pref
        && ctrl[9:8] == 2'h2 |=> DEC_VALID && DEC.fetch == FETCH_FULL)
        else $error("full prefetch not chosen for plain read");
    chk_disc_first_dword: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_IDLE && REQ.cmd == CMD_MR && ctrl[9:8] == 2'h3
        |=> DEC.fetch == FETCH_DISC1)
        else $error("disconnect on first dword not chosen");
    chk_cmd_change_retry: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_PEND && !ctrl[10] && REQ.cmd != pend.cmd
        |=> DEC_VALID && DEC.retry && !DEC.data)
        else $error("changed command was not retried");
    chk_special_complete: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_PEND && ctrl[10] && CPL_READY && is_memrd(REQ.cmd)
        && is_memrd(pend.cmd) && REQ.addr == pend.addr && REQ.be == pend.be
        |=> DEC.data && state == ST_IDLE)
        else $error("special delayed read did not complete");
    chk_max_read_size: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_IDLE && REQ.cmd == CMD_MR && REQ.pref
        && ctrl[9:8] == 2'h2 && ctrl[14:12] == 3'h6 |=> DEC.max_bytes == 13'h1000)
        else $error("read size cap wrong");
    chk_fc_pacing: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !ctrl[15] && !fc_cnt && CREDIT_FREED && !$past(CREDIT_FREED)
        |=> !FC_UPDATE)
        else $error("update sent after a single credit");
    chk_status_sticky: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ctrl[16] && !(WR && ADDR == REG_CTRL && WDATA[16]) |=> ctrl[16])
        else $error("retry status bit lost");
    chk_limit_256: assert property (@(posedge REF_CLK) disable iff (!NRST)
        expire |-> ctrl[18:17] != 2'h0 && rcnt == retry_limit(ctrl[18:17]) - 32'h1)
        else $error("expiry at wrong count");
    chk_no_limit: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ctrl[18:17] == 2'h0 |-> !expire)
        else $error("counter expired with no limit");
    chk_discard_gate: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ctrl[19] |-> !DISCARD_TIMER_EN)
        else $error("discard timer enabled while disabled");
    chk_line_full: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_IDLE && REQ.cmd == CMD_MRL && REQ.pref
        && ctrl[7:6] == 2'h2 |=> DEC.fetch == FETCH_FULL)
        else $error("read line not fully prefetched");
    chk_count_step: assert property (@(posedge REF_CLK) disable iff (!NRST)
        state == ST_PEND && REQ_VALID && !expire && next_state == ST_PEND
        |=> rcnt == $past(rcnt) + 32'h1)
        else $error("retry not counted");
    // decision port, pacing and expiry status; back-to-back requests are legal, so each check
    // looks only one cycle ahead of its trigger
    chk_fc_one_credit: assert property (@(posedge REF_CLK) disable iff (!NRST)
        ctrl[15] && CREDIT_FREED |=> FC_UPDATE)
        else $error("single credit not reported");
    chk_fc_second_credit: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !ctrl[15] && fc_cnt && CREDIT_FREED |=> FC_UPDATE)
        else $error("second credit not reported");
    chk_expire_sets: assert property (@(posedge REF_CLK) disable iff (!NRST)
        expire |=> ctrl[16] && irq_stat[I_EXPIRE])
        else $error("expiry not recorded");
    chk_plain_line: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_IDLE && REQ.cmd == CMD_MR && REQ.pref && ctrl[9:8] == 2'h0
        |=> DEC.fetch == FETCH_LINE && DEC.max_bytes == 13'h0000)
        else $error("one line fetch not chosen");
    chk_addr_mismatch: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_PEND && (REQ.addr != pend.addr || REQ.be != pend.be)
        |=> DEC.retry && !DEC.data)
        else $error("other address was completed");
    chk_dec_follows: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID |=> DEC_VALID)
        else $error("request left unanswered");
    chk_cap_first_only: assert property (@(posedge REF_CLK) disable iff (!NRST)
        REQ_VALID && state == ST_PEND |=> DEC.max_bytes == 13'h0000)
        else $error("read size on a repeat");
endmodule // prr_ctrl
`default_nettype wire

// [prr_pkg.sv]
/*
 * Constants and carrier types for the PCI-side read prefetch and retry
 * policy block. Assumes a single 20 MHz clock domain shared by all users.
 */
`default_nettype none
package prr_pkg;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h40;
    localparam logic [7:0] REG_IRQ_STAT = 8'h44;
    localparam logic [7:0] REG_IRQ_MASK = 8'h48;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0020;
    localparam logic [31:0] CTRL_RW_MASK = 32'h000e_f7f7;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // --------------------------------------------------------------
    // field positions in the control word and interrupt status
    // --------------------------------------------------------------
    localparam int F_RM_LO = 4;
    localparam int F_RL_LO = 6;
    localparam int F_MR_LO = 8;
    localparam int F_SPECIAL = 10;
    localparam int F_MAXRD_LO = 12;
    localparam int F_FC_ONE = 15;
    localparam int F_RETRY_STAT = 16;
    localparam int F_RETRY_CTL_LO = 17;
    localparam int F_DISCARD_DIS = 19;
    localparam int I_EXPIRE = 0;
    localparam int I_CMD_RETRY = 1;
    // --------------------------------------------------------------
    // retry limits, read sizes, credit thresholds
    // --------------------------------------------------------------
    localparam logic [31:0] LIM_256 = 32'h0000_0100;
    localparam logic [31:0] LIM_64K = 32'h0001_0000;
    localparam logic [31:0] LIM_2G = 32'h8000_0000;
    localparam logic [12:0] SZ_128 = 13'h0080;
    localparam logic [12:0] SZ_256 = 13'h0100;
    localparam logic [12:0] SZ_512 = 13'h0200;
    localparam logic [12:0] SZ_1K = 13'h0400;
    localparam logic [12:0] SZ_2K = 13'h0800;
    localparam logic [12:0] SZ_4K = 13'h1000;
    localparam logic [1:0] FC_STEP_TWO = 2'h2;
    localparam logic [1:0] FC_STEP_ONE = 2'h1;
    // pci memory read command codes
    localparam logic [3:0] CMD_MR = 4'h6;
    localparam logic [3:0] CMD_MRL = 4'he;
    localparam logic [3:0] CMD_MRM = 4'hc;
    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        FETCH_DWORD = 2'b00,
        FETCH_LINE = 2'b01,
        FETCH_FULL = 2'b10,
        FETCH_DISC1 = 2'b11
    } prr_fetch_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_PEND = 1'b1
    } prr_state_t;
    typedef struct packed {
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [3:0] be;
        logic pref;
    } prr_req_t;
    typedef struct packed {
        logic retry;
        logic data;
        prr_fetch_t fetch;
        logic [12:0] max_bytes;
    } prr_dec_t;
endpackage
`default_nettype wire

// [prr_pci_master.sv]
/*
 * Model of a PCI bus master that presents memory reads to the decision port.
 * Assumes the bench calls issue only after reset and on REF_CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module prr_pci_master
    import prr_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic NRST,
    output logic REQ_VALID,
    output prr_req_t REQ,
    input wire logic DEC_VALID,
    input wire prr_dec_t DEC
);
    // ----------------------------------------
    // request lines
    // ----------------------------------------
    prr_req_t req_q;
    prr_req_t junk;
    logic busy;
    // idle lines toggle each cycle so a stale request is never reused
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            junk <= '0;
        end else begin
            junk <= ~junk;
        end
    end
    assign REQ = busy ? req_q : junk;
    // nothing is presented before the first call
    initial begin
        REQ_VALID = 1'b0;
        busy = 1'b0;
        req_q = '0;
    end
    // one pulse per try; a repeat may carry another read command
    task automatic issue(input prr_req_t r, output prr_dec_t d, output logic seen);
        @(posedge REF_CLK);
        req_q <= r;
        busy <= 1'b1;
        REQ_VALID <= 1'b1;
        @(posedge REF_CLK);
        busy <= 1'b0;
        REQ_VALID <= 1'b0;
        #1;
        seen = DEC_VALID;
        d = DEC;
    endtask
endmodule // prr_pci_master
`default_nettype wire

// [prr_ctrl_test.sv]
/*
 * Self-checking bench for the read prefetch and retry policy block.
 * Assumes the package constants and a master model on the request port.
 */
`timescale 1ns/1ps
`default_nettype none
module prr_ctrl_test
    import prr_pkg::*;
;
    logic ref_clk, nrst, reg_wr, reg_rd, irq, req_valid, cpl_ready;
    logic dec_valid, credit_freed, fc_update, bridge_discard, discard_en;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    prr_req_t req;
    prr_dec_t dec;
    int checks, n_mismatch;
    // ----------------------------------------
    // design and master model
    // ----------------------------------------
    prr_ctrl dut_u (.REF_CLK(ref_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(reg_wr),
        .RD(reg_rd), .RDATA(rdata), .IRQ(irq), .REQ_VALID(req_valid), .REQ(req),
        .CPL_READY(cpl_ready), .DEC_VALID(dec_valid), .DEC(dec), .CREDIT_FREED(credit_freed),
        .FC_UPDATE(fc_update), .BRIDGE_DISCARD_BIT(bridge_discard),
        .DISCARD_TIMER_EN(discard_en));
    prr_pci_master master_u (.REF_CLK(ref_clk), .NRST(nrst), .REQ_VALID(req_valid),
        .REQ(req), .DEC_VALID(dec_valid), .DEC(dec));
    // 50 ns period
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_is(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask
    // level outputs are registered, so let two edges pass first
    task automatic later_is(input string what, input logic exp, ref logic sig);
        repeat (2) @(posedge ref_clk);
        #1;
        check(what, {31'h0, exp}, {31'h0, sig});
    endtask
    task automatic ask(input logic [3:0] c, input logic p, output prr_dec_t d);
        logic seen;
        master_u.issue('{cmd: c, addr: 32'h0000_1040, be: 4'hf, pref: p}, d, seen);
        check("dec_valid", 32'h1, {31'h0, seen});
    endtask
    task automatic done_ok(input logic [3:0] c);
        prr_dec_t d;
        ask(c, 1'b1, d);
        check("retry data", 32'h1, {30'h0, d.retry, d.data});
    endtask
    task automatic credit(input logic exp);
        @(posedge ref_clk);
        credit_freed <= 1'b1;
        @(posedge ref_clk);
        credit_freed <= 1'b0;
        #1;
        check("fc update", {31'h0, exp}, {31'h0, fc_update});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        reg_is(REG_CTRL, CTRL_RESET, "ctrl reset");
        reg_is(REG_IRQ_STAT, 32'h0, "status reset");
        reg_is(8'h4c, 32'h0, "unmapped");
        bus_wr(REG_CTRL, 32'hffff_ffff);
        reg_is(REG_CTRL, CTRL_RW_MASK, "ctrl writable");
        bus_wr(REG_CTRL, CTRL_RESET);
    endtask
    task automatic t_fetch;
        prr_dec_t d;
        logic [1:0] mode [3] = '{2'h0, 2'h2, 2'h3};
        logic [1:0] fx [3] = '{2'h1, 2'h2, 2'h3};
        logic [12:0] sz [8] = '{SZ_512, SZ_128, SZ_256, SZ_512, SZ_1K, SZ_2K, SZ_4K, SZ_512};
        @(posedge ref_clk) cpl_ready <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus_wr(REG_CTRL, {22'h0, mode[i], 8'h0});
            ask(CMD_MR, 1'b1, d);
            check("fetch", {30'h0, fx[i]}, {30'h0, d.fetch});
            check("bytes", (i == 1) ? 32'h200 : 32'h0, {19'h0, d.max_bytes});
            done_ok(CMD_MR);
        end
        for (int i = 0; i < 8; i++) begin
            bus_wr(REG_CTRL, {17'h0, i[2:0], 4'h2, 8'h0});
            ask(CMD_MR, 1'b1, d);
            check("max bytes", {19'h0, sz[i]}, {19'h0, d.max_bytes});
            done_ok(CMD_MR);
        end
        bus_wr(REG_CTRL, 32'h0000_0080);
        ask(CMD_MRL, 1'b1, d);
        check("line fetch", 32'h2, {30'h0, d.fetch});
        done_ok(CMD_MRL);
        bus_wr(REG_CTRL, CTRL_RESET);
        ask(CMD_MRM, 1'b1, d);
        check("multiple bytes", 32'h200, {19'h0, d.max_bytes});
        done_ok(CMD_MRM);
        ask(CMD_MR, 1'b0, d);
        check("plain fetch", 32'h0, {30'h0, d.fetch});
        done_ok(CMD_MR);
    endtask
    task automatic t_special;
        prr_dec_t d;
        logic seen;
        bus_wr(REG_CTRL, 32'h0);
        bus_wr(REG_IRQ_MASK, 32'h2);
        ask(CMD_MR, 1'b1, d);
        ask(CMD_MRL, 1'b1, d);
        check("swap retried", 32'h2, {30'h0, d.retry, d.data});
        later_is("irq raised", 1'b1, irq);
        done_ok(CMD_MR);
        bus_wr(REG_IRQ_MASK, 32'h0);
        later_is("irq masked", 1'b0, irq);
        reg_is(REG_IRQ_STAT, 32'h2, "swap status");
        bus_wr(REG_IRQ_STAT, 32'h2);
        reg_is(REG_IRQ_STAT, 32'h0, "status cleared");
        bus_wr(REG_CTRL, 32'h400);
        ask(CMD_MR, 1'b1, d);
        master_u.issue('{cmd: CMD_MR, addr: 32'h0000_2040, be: 4'hf, pref: 1'b1}, d, seen);
        check("other valid", 32'h1, {31'h0, seen});
        check("other addr", 32'h2, {30'h0, d.retry, d.data});
        done_ok(CMD_MRM);
        ask(CMD_MRL, 1'b1, d);
        done_ok(CMD_MR);
    endtask
    task automatic t_retry;
        prr_dec_t d;
        bus_wr(REG_IRQ_MASK, 32'h1);
        bus_wr(REG_CTRL, 32'h0002_0000);
        @(posedge ref_clk) cpl_ready <= 1'b0;
        repeat (255) ask(CMD_MR, 1'b1, d);
        reg_is(REG_CTRL, 32'h0002_0000, "before limit");
        ask(CMD_MR, 1'b1, d);
        reg_is(REG_CTRL, 32'h0003_0000, "expired");
        later_is("irq expiry", 1'b1, irq);
        bus_wr(REG_CTRL, 32'h0);
        reg_is(REG_CTRL, 32'h0001_0000, "sticky");
        bus_wr(REG_CTRL, 32'h0001_0000);
        reg_is(REG_CTRL, 32'h0, "cleared");
        bus_wr(REG_IRQ_STAT, 32'h1);
        later_is("irq cleared", 1'b0, irq);
        repeat (300) ask(CMD_MR, 1'b1, d);
        reg_is(REG_CTRL, 32'h0, "no limit");
        @(posedge ref_clk) cpl_ready <= 1'b1;
        done_ok(CMD_MR);
    endtask
    task automatic t_credit;
        bus_wr(REG_CTRL, 32'h0);
        credit(1'b0);
        credit(1'b1);
        credit(1'b0);
        credit(1'b1);
        bus_wr(REG_CTRL, 32'h8000);
        credit(1'b1);
        credit(1'b1);
    endtask
    task automatic t_discard;
        @(posedge ref_clk) bridge_discard <= 1'b1;
        bus_wr(REG_CTRL, 32'h0);
        later_is("discard on", 1'b1, discard_en);
        bus_wr(REG_CTRL, 32'h0008_0000);
        later_is("discard off", 1'b0, discard_en);
        bus_wr(REG_CTRL, 32'h0);
        @(posedge ref_clk) bridge_discard <= 1'b0;
        later_is("bridge off", 1'b0, discard_en);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {nrst, reg_wr, reg_rd, cpl_ready, credit_freed, bridge_discard} = '0;
        addr = 8'h0;
        wdata = 32'h0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs;
        t_fetch;
        t_special;
        t_retry;
        t_credit;
        t_discard;
        summarize;
    end
    // the whole run needs about 1300 cycles; a hang is cut well after
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("watchdog expired");
        summarize;
    end
endmodule // prr_ctrl_test
`default_nettype wire
